// ==== design/io_ports_map.vh ====
// constants for the configurable i/o ports
`ifndef IO_PORTS_MAP_VH
`define IO_PORTS_MAP_VH
// ----------------------------------------------------------------
// data memory addresses of the pin data registers
// ----------------------------------------------------------------
`define PORT_A_DATA_ADDR   8'h05
`define PORT_B_DATA_ADDR   8'h06
`define PORT_C_DATA_ADDR   8'h07
// ----------------------------------------------------------------
// selector codes
// ----------------------------------------------------------------
`define SEL_COMPARATOR     8'h08
`define SEL_WAKE_PENDING   8'h09
`define SEL_WAKE_EDGE      8'h0a
`define SEL_WAKE_ENABLE    8'h0b
`define SEL_SCHMITT        8'h0c
`define SEL_THRESHOLD      8'h0d
`define SEL_PULLUP         8'h0e
`define SEL_DIRECTION      8'h0f
// ----------------------------------------------------------------
// reset values and port widths
// ----------------------------------------------------------------
`define SELECTOR_RESET     8'h0f
`define CONFIG_RESET       8'hff
`define LATCH_RESET        8'h00
`define PORT_A_WIDTH       4
`define PORT_BC_WIDTH      8
`endif

// ==== design/pin_sync.v ====
// two-flop synchroniser for a group of pin levels
module pin_sync #(
	parameter WIDTH = 8
) (
	input  wire             mclk_i,
	input  wire             reset_i,
	input  wire [WIDTH-1:0] pin_i,
	output reg  [WIDTH-1:0] level_o
);
	reg [WIDTH-1:0] stage;

	// first stage feeds only the second
	always @(posedge mclk_i) begin
		if (reset_i) begin
			stage   <= {WIDTH{1'b0}};
			level_o <= {WIDTH{1'b0}};
		end else begin
			stage   <= pin_i;
			level_o <= stage;
		end
	end
endmodule

// ==== design/port_slice.v ====
// one port: output latch and configuration registers
module port_slice #(
	parameter WIDTH       = 8,
	parameter HAS_SCHMITT = 1
) (
	input  wire             mclk_i,
	input  wire             reset_i,
	input  wire             data_we_i,
	input  wire             ctl_we_i,
	input  wire [7:0]       selector_i,
	input  wire [7:0]       wdata_i,
	output reg  [WIDTH-1:0] latch_o,
	output reg  [WIDTH-1:0] direction_o,
	output reg  [WIDTH-1:0] threshold_o,
	output reg  [WIDTH-1:0] pullup_disable_o,
	output reg  [WIDTH-1:0] schmitt_disable_o
);
`include "io_ports_map.vh"

	// reset codes are a byte wide; a narrow port keeps only the low bits
	localparam [7:0] LATCH_INIT = `LATCH_RESET;
	localparam [7:0] CFG_INIT   = `CONFIG_RESET;

	// latch kept regardless of direction
	always @(posedge mclk_i) begin
		if (reset_i) begin
			latch_o           <= LATCH_INIT[WIDTH-1:0];
			direction_o       <= CFG_INIT[WIDTH-1:0]; // RL4
			threshold_o       <= CFG_INIT[WIDTH-1:0]; // RL4
			pullup_disable_o  <= CFG_INIT[WIDTH-1:0]; // RL4
			schmitt_disable_o <= CFG_INIT[WIDTH-1:0]; // RL4
		end else begin
			if (data_we_i)
				latch_o <= wdata_i[WIDTH-1:0];
			if (ctl_we_i) begin
				if (selector_i == `SEL_DIRECTION)
					direction_o <= wdata_i[WIDTH-1:0];
				else if (selector_i == `SEL_PULLUP)
					pullup_disable_o <= wdata_i[WIDTH-1:0];
				else if (selector_i == `SEL_THRESHOLD)
					threshold_o <= wdata_i[WIDTH-1:0];
				else if (selector_i == `SEL_SCHMITT && HAS_SCHMITT != 0)
					schmitt_disable_o <= wdata_i[WIDTH-1:0];
			end
		end
	end
endmodule

// ==== design/configurable_io_ports.v ====
// three configurable i/o ports behind the cpu core
// ----------------------------------------------------------------
// Summary of operation
// RL1: port a is four bits, ports b and c eight bits.
// RL2: port a registers use only low nibble; upper bits ignored.
// RL3: register bit n controls or reflects pin n.
// RL4: reset sets all configuration bits to one.
// RL5: direction one is hi-z input, zero enables driver.
// RL6: data registers sit at addresses 05h, 06h, 07h.
// RL7: data write stores latch, drives output pins.
// RL8: latch written while input drives later once output.
// RL9: data read returns sampled pins, never latch.
// RL10: driven-high pin held low reads zero.
// RL11: software puts a nop between back-to-back bit operations.
// RL12: control write targets register chosen by port and selector.
// RL13: selector not in data memory; own write and read.
// RL14: reset loads selector with 0fh.
// RL15: selector holds until software writes it again.
// RL16: software loads only selector values 08h to 0fh.
// RL17: selector 0eh routes control writes to pullup registers.
// RL18: pullup bit one disconnects, zero connects.
// RL19: schmitt selection only on ports b and c.
// RL20: port b pins also serve wakeup and comparator.
// RL21: threshold bit one ttl, zero cmos.
// RL22: schmitt bit zero enables schmitt under selector 0ch.
// RL23: wake edge under 0ah: zero rising, one falling.
// RL24: control writes with no target register are ignored.
// ----------------------------------------------------------------
module configurable_io_ports #(
	parameter A_WIDTH = 4,
	parameter B_WIDTH = 8,
	parameter C_WIDTH = 8
) (
	input  wire               mclk_i,
	input  wire               reset_i,
	input  wire [7:0]         file_addr_i,
	input  wire               file_we_i,
	input  wire               file_re_i,
	input  wire [7:0]         file_wdata_i,
	output reg  [7:0]         file_rdata_o,
	output reg                file_hit_o,
	input  wire               sel_we_i,
	input  wire [7:0]         sel_wdata_i,
	output wire [7:0]         selector_o,
	input  wire               ctl_we_a_i,
	input  wire               ctl_we_b_i,
	input  wire               ctl_we_c_i,
	input  wire [7:0]         ctl_wdata_i,
	input  wire [A_WIDTH-1:0] port_a_i,
	output wire [A_WIDTH-1:0] port_a_o,
	output wire [A_WIDTH-1:0] port_a_oe_n_o,
	output wire [A_WIDTH-1:0] port_a_pullup_disable_o,
	output wire [A_WIDTH-1:0] port_a_input_threshold_o,
	input  wire [B_WIDTH-1:0] port_b_i,
	output wire [B_WIDTH-1:0] port_b_o,
	output wire [B_WIDTH-1:0] port_b_oe_n_o,
	output wire [B_WIDTH-1:0] port_b_pullup_disable_o,
	output wire [B_WIDTH-1:0] port_b_input_threshold_o,
	output wire [B_WIDTH-1:0] port_b_schmitt_disable_o,
	output wire [B_WIDTH-1:0] port_b_level_o,
	output reg                wake_reg_we_o,
	output reg  [7:0]         wake_reg_sel_o,
	output reg  [7:0]         wake_reg_wdata_o,
	input  wire [C_WIDTH-1:0] port_c_i,
	output wire [C_WIDTH-1:0] port_c_o,
	output wire [C_WIDTH-1:0] port_c_oe_n_o,
	output wire [C_WIDTH-1:0] port_c_pullup_disable_o,
	output wire [C_WIDTH-1:0] port_c_input_threshold_o,
	output wire [C_WIDTH-1:0] port_c_schmitt_disable_o
);
`include "io_ports_map.vh"

	// ----------------------------------------------------------------
	// selector
	// ----------------------------------------------------------------
	reg  [7:0] selector;
	wire [7:0] next_selector;

	// a stray reserved code is stored as written; it simply reaches nothing
	assign next_selector = sel_we_i ? sel_wdata_i : selector; // RL15
	always @(posedge mclk_i) begin
		if (reset_i)
			selector <= `SELECTOR_RESET; // RL14
		else
			selector <= next_selector; // RL13
	end
	assign selector_o = selector; // RL13

	// ----------------------------------------------------------------
	// data write decode
	// ----------------------------------------------------------------
	reg we_a;
	reg we_b;
	reg we_c;

	always @* begin
		we_a = 1'b0;
		we_b = 1'b0;
		we_c = 1'b0;
		if (file_we_i && file_addr_i == `PORT_A_DATA_ADDR)
			we_a = 1'b1; // RL6
		else if (file_we_i && file_addr_i == `PORT_B_DATA_ADDR)
			we_b = 1'b1; // RL6
		else if (file_we_i && file_addr_i == `PORT_C_DATA_ADDR)
			we_c = 1'b1; // RL6
	end

	// ----------------------------------------------------------------
	// port slices
	// ----------------------------------------------------------------
	wire [A_WIDTH-1:0] latch_a;
	wire [A_WIDTH-1:0] dir_a;
	wire [B_WIDTH-1:0] latch_b;
	wire [B_WIDTH-1:0] dir_b;
	wire [C_WIDTH-1:0] latch_c;
	wire [C_WIDTH-1:0] dir_c;

	// port a slice has no schmitt register; its writes under 0ch drop
	port_slice #(.WIDTH(A_WIDTH), .HAS_SCHMITT(0)) u_port_a ( // RL19
		.mclk_i            (mclk_i),
		.reset_i           (reset_i),
		.data_we_i         (we_a),
		.ctl_we_i          (ctl_we_a_i), // RL12
		.selector_i        (selector),
		.wdata_i           (we_a ? file_wdata_i : ctl_wdata_i), // RL2
		.latch_o           (latch_a),
		.direction_o       (dir_a),
		.threshold_o       (port_a_input_threshold_o),
		.pullup_disable_o  (port_a_pullup_disable_o),
		.schmitt_disable_o ()
	);

	port_slice #(.WIDTH(B_WIDTH), .HAS_SCHMITT(1)) u_port_b (
		.mclk_i            (mclk_i),
		.reset_i           (reset_i),
		.data_we_i         (we_b),
		.ctl_we_i          (ctl_we_b_i), // RL12
		.selector_i        (selector),
		.wdata_i           (we_b ? file_wdata_i : ctl_wdata_i),
		.latch_o           (latch_b),
		.direction_o       (dir_b),
		.threshold_o       (port_b_input_threshold_o), // RL21
		.pullup_disable_o  (port_b_pullup_disable_o), // RL17
		.schmitt_disable_o (port_b_schmitt_disable_o) // RL22
	);

	port_slice #(.WIDTH(C_WIDTH), .HAS_SCHMITT(1)) u_port_c (
		.mclk_i            (mclk_i),
		.reset_i           (reset_i),
		.data_we_i         (we_c),
		.ctl_we_i          (ctl_we_c_i), // RL12
		.selector_i        (selector),
		.wdata_i           (we_c ? file_wdata_i : ctl_wdata_i),
		.latch_o           (latch_c),
		.direction_o       (dir_c),
		.threshold_o       (port_c_input_threshold_o),
		.pullup_disable_o  (port_c_pullup_disable_o), // RL18
		.schmitt_disable_o (port_c_schmitt_disable_o)
	);

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	// latch goes out whenever direction is zero, whatever came first
	assign port_a_o      = latch_a; // RL7 RL8
	assign port_a_oe_n_o = dir_a; // RL5
	assign port_b_o      = latch_b; // RL7
	assign port_b_oe_n_o = dir_b; // RL5
	assign port_c_o      = latch_c; // RL3
	assign port_c_oe_n_o = dir_c; // RL5

	// ----------------------------------------------------------------
	// pin sampling
	// ----------------------------------------------------------------
	wire [A_WIDTH-1:0] level_a;
	wire [B_WIDTH-1:0] level_b;
	wire [C_WIDTH-1:0] level_c;

	pin_sync #(.WIDTH(A_WIDTH)) u_sync_a (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.pin_i   (port_a_i),
		.level_o (level_a)
	);

	pin_sync #(.WIDTH(B_WIDTH)) u_sync_b (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.pin_i   (port_b_i),
		.level_o (level_b)
	);

	pin_sync #(.WIDTH(C_WIDTH)) u_sync_c (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.pin_i   (port_c_i),
		.level_o (level_c)
	);

	// synchronised port b levels go to the wakeup and comparator logic
	assign port_b_level_o = level_b; // RL20

	// ----------------------------------------------------------------
	// file register read
	// ----------------------------------------------------------------
	reg [7:0] next_rdata;
	reg       next_hit;

	// the pin, not the latch, is read so a shorted output reads low
	always @* begin
		next_rdata = 8'h00;
		next_hit   = 1'b0;
		if (file_addr_i == `PORT_A_DATA_ADDR) begin
			next_rdata = {{(8-A_WIDTH){1'b0}}, level_a}; // RL9 RL2
			next_hit   = 1'b1;
		end else if (file_addr_i == `PORT_B_DATA_ADDR) begin
			next_rdata = level_b; // RL9 RL10
			next_hit   = 1'b1;
		end else if (file_addr_i == `PORT_C_DATA_ADDR) begin
			next_rdata = level_c; // RL9 RL1
			next_hit   = 1'b1;
		end
	end

	always @(posedge mclk_i) begin
		if (reset_i) begin
			file_rdata_o <= 8'h00;
			file_hit_o   <= 1'b0;
		end else begin
			file_rdata_o <= file_re_i ? next_rdata : 8'h00;
			file_hit_o   <= file_re_i & next_hit;
		end
	end

	// ----------------------------------------------------------------
	// port b wakeup and comparator hand-off
	// ----------------------------------------------------------------
	// codes 08h-0bh belong to logic outside this block; pass them on
	always @(posedge mclk_i) begin
		if (reset_i) begin
			wake_reg_we_o    <= 1'b0;
			wake_reg_sel_o   <= 8'h00;
			wake_reg_wdata_o <= 8'h00;
		end else begin
			wake_reg_we_o <= ctl_we_b_i &&
				selector >= `SEL_COMPARATOR &&
				selector <= `SEL_WAKE_ENABLE; // RL20 RL23 RL24
			wake_reg_sel_o   <= selector;
			wake_reg_wdata_o <= ctl_wdata_i;
		end
	end
endmodule

// ==== sim/configurable_io_ports_props.sv ====
// assertions on the ports of the configurable i/o block
module io_ports_props #(
	parameter A_WIDTH = 4,
	parameter B_WIDTH = 8,
	parameter C_WIDTH = 8
) (
	input wire               mclk_i,
	input wire               reset_i,
	input wire [7:0]         file_addr_i,
	input wire               file_we_i,
	input wire               file_re_i,
	input wire [7:0]         file_wdata_i,
	input wire               file_hit_o,
	input wire               sel_we_i,
	input wire [7:0]         sel_wdata_i,
	input wire [7:0]         selector_o,
	input wire               ctl_we_a_i,
	input wire               ctl_we_b_i,
	input wire               ctl_we_c_i,
	input wire [7:0]         ctl_wdata_i,
	input wire [A_WIDTH-1:0] port_a_oe_n_o,
	input wire [B_WIDTH-1:0] port_b_o,
	input wire [B_WIDTH-1:0] port_b_oe_n_o,
	input wire               wake_reg_we_o,
	input wire [7:0]         wake_reg_sel_o,
	input wire [7:0]         wake_reg_wdata_o,
	input wire [C_WIDTH-1:0] port_c_pullup_disable_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	rst_val_a: assert property (
		$fell(reset_i) |-> selector_o == 8'h0f && &port_b_oe_n_o)
		else $error("reset state wrong");
	sel_load_a: assert property (
		sel_we_i |=> selector_o == $past(sel_wdata_i)) else $error("sel load");
	sel_hold_a: assert property (
		!sel_we_i |=> $stable(selector_o)) else $error("sel changed");
	dir_b_a: assert property (
		ctl_we_b_i && selector_o == 8'h0f
		|=> port_b_oe_n_o == $past(ctl_wdata_i)) else $error("dir b");
	pullup_c_a: assert property (
		ctl_we_c_i && selector_o == 8'h0e
		|=> port_c_pullup_disable_o == $past(ctl_wdata_i)) else $error("pup c");
	latch_b_a: assert property (
		file_we_i && file_addr_i == 8'h06
		|=> port_b_o == $past(file_wdata_i)) else $error("latch b");
	a_ignore_a: assert property (
		ctl_we_a_i && selector_o inside {[8'h08:8'h0c]}
		|=> $stable(port_a_oe_n_o)) else $error("port a write");
	hit_map_a: assert property (
		file_re_i |=> file_hit_o == ($past(file_addr_i) inside
		{8'h05, 8'h06, 8'h07})) else $error("hit map");
	wake_fwd_a: assert property (
		ctl_we_b_i && selector_o inside {[8'h08:8'h0b]}
		|=> wake_reg_we_o) else $error("wake forward");
	wake_data_a: assert property (
		ctl_we_b_i && selector_o inside {[8'h08:8'h0b]}
		|=> wake_reg_sel_o == $past(selector_o)
		&& wake_reg_wdata_o == $past(ctl_wdata_i)) else $error("wake data");
	wake_quiet_a: assert property (
		!(ctl_we_b_i && selector_o inside {[8'h08:8'h0b]})
		|=> !wake_reg_we_o) else $error("wake stray");
endmodule
bind configurable_io_ports io_ports_props #(.A_WIDTH(A_WIDTH),
	.B_WIDTH(B_WIDTH), .C_WIDTH(C_WIDTH)) i_props (.mclk_i, .reset_i,
	.file_addr_i, .file_we_i, .file_re_i, .file_wdata_i, .file_hit_o,
	.sel_we_i, .sel_wdata_i, .selector_o, .ctl_we_a_i, .ctl_we_b_i,
	.ctl_we_c_i, .ctl_wdata_i, .port_a_oe_n_o, .port_b_o, .port_b_oe_n_o,
	.wake_reg_we_o, .wake_reg_sel_o, .wake_reg_wdata_o,
	.port_c_pullup_disable_o);

// ==== sim/pin_board.sv ====
// board side of one port: drivers, pullups and clamps on the pins
module pin_board #(
	parameter W = 8
) (
	input  wire logic [W-1:0] drv_i,
	input  wire logic [W-1:0] oe_n_i,
	input  wire logic [W-1:0] pud_i,
	input  wire logic [W-1:0] ext_i,
	input  wire logic [W-1:0] clamp_i,
	output logic      [W-1:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// clamp beats the driver; ext is a weak source the pullup overrides
	assign pin_o = ~clamp_i & (~oe_n_i & drv_i
		| oe_n_i & (ext_i | ~pud_i));
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the configurable i/o ports
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       file_we_i, file_re_i, sel_we_i, file_hit_o;
	logic       ctl_we_a_i, ctl_we_b_i, ctl_we_c_i;
	logic [7:0] file_addr_i, file_wdata_i, sel_wdata_i, ctl_wdata_i;
	logic [7:0] file_rdata_o, selector_o;
	logic [3:0] port_a_i, port_a_o, port_a_oe_n_o;
	logic [3:0] port_a_pullup_disable_o, port_a_input_threshold_o;
	logic [7:0] port_b_i, port_b_o, port_b_oe_n_o, port_b_pullup_disable_o;
	logic [7:0] port_b_input_threshold_o, port_b_schmitt_disable_o;
	logic [7:0] port_c_i, port_c_o, port_c_oe_n_o, port_c_pullup_disable_o;
	logic [7:0] port_c_input_threshold_o, port_c_schmitt_disable_o;
	logic [7:0] port_b_level_o;
	logic [7:0] dir[3], lat[3], pud[3], thr[3], st[3], sel_s;
	logic [7:0] ext[3] = '{default: 8'h00};
	logic [7:0] clp[3] = '{default: 8'h00};
	logic [7:0] q[$];
	int         mismatches = 0;
	int         n_compared = 0;
	int         cyc = 0;
	wire [19:0] oe_w = {port_a_oe_n_o, port_b_oe_n_o, port_c_oe_n_o};
	wire [19:0] pu_w = {port_a_pullup_disable_o, port_b_pullup_disable_o,
		port_c_pullup_disable_o};
	wire [19:0] th_w = {port_a_input_threshold_o, port_b_input_threshold_o,
		port_c_input_threshold_o};
	wire [15:0] st_w = {port_b_schmitt_disable_o, port_c_schmitt_disable_o};
	wire [19:0] out_w = {port_a_o, port_b_o, port_c_o};
	configurable_io_ports i_dut (.mclk_i, .reset_i, .file_addr_i, .file_we_i,
		.file_re_i, .file_wdata_i, .file_rdata_o, .file_hit_o, .sel_we_i,
		.sel_wdata_i, .selector_o, .ctl_we_a_i, .ctl_we_b_i, .ctl_we_c_i,
		.ctl_wdata_i, .port_a_i, .port_a_o, .port_a_oe_n_o,
		.port_a_pullup_disable_o, .port_a_input_threshold_o, .port_b_i,
		.port_b_o, .port_b_oe_n_o, .port_b_pullup_disable_o,
		.port_b_input_threshold_o, .port_b_schmitt_disable_o,
		.port_b_level_o, .wake_reg_we_o(), .wake_reg_sel_o(),
		.wake_reg_wdata_o(), .port_c_i, .port_c_o, .port_c_oe_n_o,
		.port_c_pullup_disable_o, .port_c_input_threshold_o,
		.port_c_schmitt_disable_o);
	pin_board #(.W(4)) i_pa (.drv_i(port_a_o), .oe_n_i(port_a_oe_n_o),
		.pud_i(port_a_pullup_disable_o), .ext_i(ext[0][3:0]),
		.clamp_i(clp[0][3:0]), .pin_o(port_a_i));
	pin_board #(.W(8)) i_pb (.drv_i(port_b_o), .oe_n_i(port_b_oe_n_o),
		.pud_i(port_b_pullup_disable_o), .ext_i(ext[1]), .clamp_i(clp[1]),
		.pin_o(port_b_i));
	pin_board #(.W(8)) i_pc (.drv_i(port_c_o), .oe_n_i(port_c_oe_n_o),
		.pud_i(port_c_pullup_disable_o), .ext_i(ext[2]), .clamp_i(clp[2]),
		.pin_o(port_c_i));
	initial forever #12.5 mclk_i = ~mclk_i;
	// --------------------------------------------------------------
	// bus tasks: every strobe assigned once per edge
	// --------------------------------------------------------------
	task automatic op(input int k, input logic [7:0] a, d);
		file_we_i <= k == 1;
		file_re_i <= k == 2;
		sel_we_i <= k == 3;
		{ctl_we_c_i, ctl_we_b_i, ctl_we_a_i} <= k > 3 ? 3'h1 << (k - 4) : 3'h0;
		file_addr_i <= a;
		file_wdata_i <= d;
		sel_wdata_i <= d;
		ctl_wdata_i <= d;
		@(posedge mclk_i);
	endtask
	task automatic ctl(input int p, input logic [7:0] d);
		op(4 + p, 8'h00, d);
		case (sel_s)
		8'h0f: dir[p] = d;
		8'h0e: pud[p] = d;
		8'h0d: thr[p] = d;
		8'h0c: if (p > 0) st[p] = d;
		default: ;
		endcase
	endtask
	task automatic wr(input int p, input logic [7:0] d);
		lat[p] = d;
		op(1, 8'(5 + p), d);
	endtask
	function automatic logic [7:0] pin(input int p);
		logic [7:0] m;
		m = p == 0 ? 8'h0f : 8'hff;
		return m & ~clp[p] & (~dir[p] & lat[p] | dir[p] & (ext[p] | ~pud[p]));
	endfunction
	task automatic rd(input int p);
		if (p >= 0) q.push_back(pin(p));
		op(2, 8'(5 + p), 8'h00);
	endtask
	function automatic logic [19:0] ex(input logic [7:0] r[3]);
		return {r[0][3:0], r[1], r[2]};
	endfunction
	task automatic chk_cfg;
		`CHK(oe_w, ex(dir))
		`CHK(pu_w, ex(pud))
		`CHK(th_w, ex(thr))
		`CHK(st_w, {st[1], st[2]})
	endtask
	task automatic chk_rst;
		foreach (dir[i]) {dir[i], pud[i], thr[i], st[i], lat[i]} = 40'hffffffff00;
		sel_s = 8'h0f;
		`CHK(selector_o, 8'h0f)
		`CHK(out_w, ex(lat))
		chk_cfg();
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		logic [7:0] e;
		if (file_hit_o === 1'b1) begin
			e = q.size() > 0 ? q.pop_front() : 8'hxx;
			`CHK(file_rdata_o, e)
		end
	end
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge mclk_i) if (++cyc == 2000) begin
		mismatches++;
		conclude();
	end
	initial begin
		void'($urandom(32'hebac519f));
		repeat (6) op(0, 8'h00, 8'h00);
		reset_i <= 1'b0;
		op(0, 8'h00, 8'h00);
		chk_rst();
		wr(0, 8'hfa);
		wr(1, 8'ha5);
		wr(2, 8'h3c);
		op(0, 8'h00, 8'h00);
		`CHK(out_w, ex(lat))
		`CHK(oe_w, 20'hfffff)
		for (int s = 8'h08; s < 8'h10; s++) begin
			sel_s = 8'(s);
			op(3, 8'h00, sel_s);
			for (int p = 0; p < 3; p++) ctl(p, 8'($urandom));
			op(0, 8'h00, 8'h00);
			`CHK(selector_o, sel_s)
			chk_cfg();
		end
		repeat (8) begin
			foreach (ext[p]) begin
				ext[p] <= 8'($urandom);
				clp[p] <= 8'($urandom & $urandom);
			end
			for (int p = 0; p < 3; p++) ctl(p, 8'($urandom));
			wr(1, 8'($urandom));
			repeat (3) op(0, 8'h00, 8'h00);
			`CHK(port_b_level_o, pin(1))
			for (int p = -1; p < 3; p++) rd(p);
			op(0, 8'h00, 8'h00);
		end
		chk_cfg();
		reset_i <= 1'b1;
		repeat (2) op(0, 8'h00, 8'h00);
		reset_i <= 1'b0;
		op(0, 8'h00, 8'h00);
		chk_rst();
		`CHK(q.size(), 0)
		conclude();
	end
endmodule
